// ==== logic/sync_port_core.sv ====
// stop-condition collision check, baud counter and status register of the serial port
//
// Behaviour
// R01: sda low after released and timeout is collision
// R02: scl low before sda high is collision
// R03: stop: sda low, release scl, count, sample
// R04: shift buffer write in master starts counter
// R05: counter stops when operation ends, clock holds
// R06: counter reloaded twice per serial clock period
// R07: clock equals sysclk over four times reload-plus-one
// R08: software avoids reload values 0..2 in i2c
// R09: status bit 7 selects spi sample phase
// R10: status bit 7 disables slew control in i2c
// R11: status bit 6 selects spi transmit edge
// R12: status bit 6 selects smbus thresholds in i2c
// R13: data-not-address bit tracks last byte kind
// R14: stop-seen bit, cleared by reset or disable
// R15: start-seen bit, cleared by reset or disable
// R16: slave read-write bit holds last matched direction
// R17: master read-write bit shows transmit in progress
// R18: address-update bit requests reload register rewrite
// R19: buffer-full sets on receive, clears when empty
// R20: buffer-full stays set during transmitted data bits
// R21: collision sets flag, port returns to idle
// R22: collision aborts condition, releases pins, clears requests
// R23: collision flag gated by enable onto interrupt
`timescale 1ns/10ps
module sync_port_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [ADDR_W-1:0]           i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_sda,
  output logic                             o_sda,
  output logic                             o_sda_oe,
  input  wire logic                        i_scl,
  output logic                             o_scl,
  output logic                             o_scl_oe,
  input  wire sync_port_pkg::engine_evt_t  i_evt,
  output sync_port_pkg::engine_ctl_t       o_ctl,
  output logic                             o_irq
);

  // whole block state
  typedef struct packed {
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [7:0]                 reload;
    logic [7:0]                 sbuf;
    logic [7:0]                 con1;
    logic [7:0]                 con2;
    logic [7:0]                 con3;
    logic [7:0]                 mask;
    logic [7:0]                 stat;
    logic [1:0]                 irq_flag;
    logic [1:0]                 irq_en;
    logic                       irq;
    logic [2:0]                 sda_s;
    logic [2:0]                 scl_s;
    logic                       sda_f;
    logic                       scl_f;
    logic                       sda_p;
    logic                       scl_p;
    logic [7:0]                 baud_cnt;
    logic [1:0]                 pre_cnt;
    logic                       baud_run;
    logic                       baud_tick;
    logic                       baud_clk;
    sync_port_pkg::stop_state_t stop_st;
    logic                       sda_oe;
    logic                       scl_oe;
    sync_port_pkg::engine_ctl_t ctl;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  // mode decoding used in several places
  function automatic logic mode_is_spi_master(input logic [3:0] m);
    mode_is_spi_master = (m <= sync_port_pkg::MODE_SPI_M_TMR) || (m == sync_port_pkg::MODE_SPI_M_BAUD);
  endfunction

  function automatic logic mode_is_spi(input logic [3:0] m);
    mode_is_spi = mode_is_spi_master(m) || (m == sync_port_pkg::MODE_SPI_S_LO) ||
                  (m == sync_port_pkg::MODE_SPI_S_HI);
  endfunction

  logic [3:0]  mode;
  logic        en;
  logic        i2c_master;
  logic        master;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  a8;
  logic [7:0]  wd;
  logic [7:0]  rdata;
  logic        unmapped;
  logic        start_det;
  logic        stop_det;
  logic        baud_zero;
  logic        coll;
  logic        buf_wr;
  logic        buf_rd;
  logic        stop_busy;

  always_comb begin
    s_d        = s_q;
    mode       = s_q.con1[sync_port_pkg::C1_MODE_HI -: 4];
    en         = s_q.con1[sync_port_pkg::C1_PORT_EN];
    i2c_master = en && (mode == sync_port_pkg::MODE_I2C_MASTER);
    master     = en && (i2c_master || mode_is_spi_master(mode));
    stop_busy  = (s_q.stop_st != sync_port_pkg::STOP_IDLE);
    coll       = 1'b0;

    // apb access phase: one wait cycle, then the answer
    acc      = i_psel && i_penable && s_q.pready;
    wr       = acc && i_pwrite;
    rd       = acc && !i_pwrite;
    a8       = 8'(i_paddr);
    wd       = i_pwdata[7:0];
    unmapped = 1'b0;
    rdata    = 8'h00;
    if (a8 == sync_port_pkg::OFF_BAUD_RELOAD) begin
      rdata = s_q.reload;
    end else if (a8 == sync_port_pkg::OFF_SHIFT_BUFFER) begin
      rdata = s_q.sbuf;
    end else if (a8 == sync_port_pkg::OFF_CONTROL_ONE) begin
      rdata = s_q.con1;
    end else if (a8 == sync_port_pkg::OFF_CONTROL_TWO) begin
      rdata = s_q.con2;
    end else if (a8 == sync_port_pkg::OFF_CONTROL_THR) begin
      rdata = s_q.con3;
    end else if (a8 == sync_port_pkg::OFF_ADDR_MASK) begin
      rdata = s_q.mask;
    end else if (a8 == sync_port_pkg::OFF_PORT_STATUS) begin
      rdata = s_q.stat;
    end else if (a8 == sync_port_pkg::OFF_IRQ_FLAGS) begin
      rdata = {6'h00, s_q.irq_flag};
    end else if (a8 == sync_port_pkg::OFF_IRQ_ENABLE) begin
      rdata = {6'h00, s_q.irq_en};
    end else begin
      unmapped = 1'b1;
    end
    s_d.pready  = i_psel && i_penable && !s_q.pready;
    s_d.prdata  = s_d.pready ? {24'h000000, rdata} : s_q.prdata;
    s_d.pslverr = s_d.pready && unmapped;
    buf_wr      = wr && !unmapped && (a8 == sync_port_pkg::OFF_SHIFT_BUFFER);
    buf_rd      = rd && (a8 == sync_port_pkg::OFF_SHIFT_BUFFER);

    // pin synchronisers; a level counts once the last two stages agree
    s_d.sda_s = {s_q.sda_s[1:0], i_sda};
    s_d.scl_s = {s_q.scl_s[1:0], i_scl};
    if (s_q.sda_s[1] == s_q.sda_s[2]) begin
      s_d.sda_f = s_q.sda_s[2];
    end
    if (s_q.scl_s[1] == s_q.scl_s[2]) begin
      s_d.scl_f = s_q.scl_s[2];
    end
    s_d.sda_p = s_q.sda_f;
    s_d.scl_p = s_q.scl_f;
    start_det = s_q.scl_f && s_q.scl_p && s_q.sda_p && !s_q.sda_f;
    stop_det  = s_q.scl_f && s_q.scl_p && !s_q.sda_p && s_q.sda_f;

    // register writes
    if (wr && (a8 == sync_port_pkg::OFF_BAUD_RELOAD)) begin
      s_d.reload                              = wd;
      s_d.stat[sync_port_pkg::ST_ADDR_UPDATE] = 1'b0;
    end
    if (wr && (a8 == sync_port_pkg::OFF_CONTROL_ONE)) begin
      s_d.con1 = wd;
    end
    if (wr && (a8 == sync_port_pkg::OFF_CONTROL_TWO)) begin
      // request bits are set-only from software; others plain
      s_d.con2 = wd | (s_q.con2 & sync_port_pkg::C2_REQ_MASK);
    end
    if (wr && (a8 == sync_port_pkg::OFF_CONTROL_THR)) begin
      s_d.con3 = wd;
    end
    if (wr && (a8 == sync_port_pkg::OFF_ADDR_MASK)) begin
      s_d.mask = wd;
    end
    if (wr && (a8 == sync_port_pkg::OFF_PORT_STATUS)) begin
      s_d.stat[sync_port_pkg::ST_SAMPLE_PHASE] = wd[sync_port_pkg::ST_SAMPLE_PHASE]; // see R09
      s_d.stat[sync_port_pkg::ST_CLOCK_EDGE]   = wd[sync_port_pkg::ST_CLOCK_EDGE];   // see R11
    end
    if (wr && (a8 == sync_port_pkg::OFF_IRQ_FLAGS)) begin
      s_d.irq_flag = s_q.irq_flag & ~wd[1:0]; // write one to clear
    end
    if (wr && (a8 == sync_port_pkg::OFF_IRQ_ENABLE)) begin
      s_d.irq_en = wd[1:0];
    end

    // shift buffer: writes refused during a stop sequence
    s_d.ctl.tx_load = 1'b0;
    if (buf_wr) begin
      if (stop_busy) begin
        s_d.con1[sync_port_pkg::C1_WRITE_COLL] = 1'b1;
      end else begin
        s_d.sbuf        = wd;
        s_d.ctl.tx_load = 1'b1;
        s_d.ctl.tx_data = wd;
        if (master) begin
          s_d.baud_run = 1'b1;                  // see R04
          s_d.baud_cnt = s_q.reload;            // see R04
          s_d.pre_cnt  = 2'b00;
        end
        if (en && !mode_is_spi(mode)) begin
          s_d.stat[sync_port_pkg::ST_BUFFER_FULL] = 1'b1; // see R20
        end
      end
    end

    // buffer-full: clear on read or end of data bits, set wins
    if ((buf_rd || i_evt.tx_done) && !s_d.ctl.tx_load) begin
      s_d.stat[sync_port_pkg::ST_BUFFER_FULL] = 1'b0; // see R19 R20
    end
    if (i_evt.rx_done) begin
      s_d.sbuf                                = i_evt.rx_data;
      s_d.stat[sync_port_pkg::ST_BUFFER_FULL] = 1'b1; // see R19
    end

    // byte kind, direction and address-update tracking
    if (i_evt.rx_done || i_evt.tx_done) begin
      s_d.stat[sync_port_pkg::ST_DATA_NADDR] = i_evt.byte_is_data; // see R13
    end
    if (i2c_master) begin
      s_d.stat[sync_port_pkg::ST_READ_WRITE] = i_evt.xmit_active; // see R17
    end else begin
      if (start_det || stop_det || i_evt.nack_seen) begin
        s_d.stat[sync_port_pkg::ST_READ_WRITE] = 1'b0;
      end
      if (i_evt.addr_matched) begin
        s_d.stat[sync_port_pkg::ST_READ_WRITE] = i_evt.addr_rw; // see R16
      end
    end
    if (i_evt.addr_update) begin
      s_d.stat[sync_port_pkg::ST_ADDR_UPDATE] = 1'b1; // see R18
    end

    // last bus condition seen
    if (stop_det) begin
      s_d.stat[sync_port_pkg::ST_STOP_SEEN]  = 1'b1; // see R14
      s_d.stat[sync_port_pkg::ST_START_SEEN] = 1'b0;
      s_d.irq_flag[sync_port_pkg::IRQ_PORT_EVENT] = 1'b1;
    end else if (start_det) begin
      s_d.stat[sync_port_pkg::ST_START_SEEN] = 1'b1; // see R15
      s_d.stat[sync_port_pkg::ST_STOP_SEEN]  = 1'b0;
    end
    if (!en) begin
      s_d.stat[sync_port_pkg::ST_STOP_SEEN]  = 1'b0; // see R14
      s_d.stat[sync_port_pkg::ST_START_SEEN] = 1'b0; // see R15
    end

    // request bits retired by the byte engine
    s_d.con2[4:0] = s_d.con2[4:0] & ~i_evt.req_done;

    // baud counter: prescaled down-count, reload on zero twice per period
    s_d.baud_tick = 1'b0;
    baud_zero     = 1'b0;
    if (s_q.baud_run) begin
      s_d.pre_cnt = (s_q.pre_cnt == sync_port_pkg::BAUD_PRE_LAST) ? 2'b00 : s_q.pre_cnt + 2'b01;
      if (s_q.pre_cnt == sync_port_pkg::BAUD_PRE_LAST) begin
        if (s_q.baud_cnt == 8'h00) begin
          baud_zero     = 1'b1;
          s_d.baud_cnt  = s_q.reload;           // see R06
          s_d.baud_tick = 1'b1;
          if (!stop_busy) begin
            s_d.baud_clk = !s_q.baud_clk;       // see R07
          end
        end else begin
          s_d.baud_cnt = s_q.baud_cnt - 8'h01;
        end
      end
    end
    if ((i_evt.op_done && !stop_busy) || !master) begin
      s_d.baud_run = 1'b0;                      // see R05
    end

    // stop sequence with collision checks
    case (s_q.stop_st)
      sync_port_pkg::STOP_IDLE: begin
        if (i2c_master && s_q.con2[sync_port_pkg::C2_STOP_REQ] && !i_evt.xmit_active) begin
          s_d.stop_st = sync_port_pkg::STOP_SDA;
          s_d.sda_oe  = 1'b1;                   // see R03
          s_d.scl_oe  = 1'b1;
        end else begin
          s_d.sda_oe = i_evt.sda_low;
          s_d.scl_oe = i_evt.scl_low;
        end
      end
      sync_port_pkg::STOP_SDA: begin
        if (!s_q.sda_f) begin
          s_d.scl_oe  = 1'b0;                   // see R03
          s_d.stop_st = sync_port_pkg::STOP_SCL;
        end
      end
      sync_port_pkg::STOP_SCL: begin
        if (s_q.scl_f) begin
          s_d.baud_cnt = s_q.reload;            // see R03
          s_d.pre_cnt  = 2'b00;
          s_d.baud_run = 1'b1;
          s_d.stop_st  = sync_port_pkg::STOP_HOLD;
        end
      end
      sync_port_pkg::STOP_HOLD: begin
        if (!s_q.scl_f) begin
          coll = 1'b1;                          // see R02
        end else if (baud_zero) begin
          s_d.sda_oe  = 1'b0;
          s_d.stop_st = sync_port_pkg::STOP_REL;
        end
      end
      sync_port_pkg::STOP_REL: begin
        if (!s_q.scl_f && !s_q.sda_f) begin
          coll = 1'b1;                          // see R02
        end else if (baud_zero) begin
          if (!s_q.sda_f) begin
            coll = 1'b1;                        // see R01
          end else begin
            s_d.stop_st = sync_port_pkg::STOP_DONE;
          end
        end
      end
      sync_port_pkg::STOP_DONE: begin
        if (baud_zero) begin
          s_d.con2[sync_port_pkg::C2_STOP_REQ]        = 1'b0;
          s_d.irq_flag[sync_port_pkg::IRQ_PORT_EVENT] = 1'b1;
          s_d.baud_run                                = 1'b0;
          s_d.stop_st                                 = sync_port_pkg::STOP_IDLE;
        end
      end
      default: begin
        s_d.stop_st = sync_port_pkg::STOP_IDLE;
      end
    endcase

    // collision: abort, release pins, clear requests, go idle
    s_d.ctl.abort = coll;
    if (coll) begin
      s_d.irq_flag[sync_port_pkg::IRQ_BUS_COLL] = 1'b1;                   // see R21 R23
      s_d.stop_st                               = sync_port_pkg::STOP_IDLE; // see R21
      s_d.sda_oe                                = 1'b0;                   // see R22
      s_d.scl_oe                                = 1'b0;                   // see R22
      s_d.con2                                  = s_d.con2 & ~sync_port_pkg::C2_REQ_MASK; // see R22
      s_d.stat[sync_port_pkg::ST_BUFFER_FULL]   = 1'b0;
      s_d.baud_run                              = 1'b0;
    end
    if (!en) begin
      s_d.stop_st = sync_port_pkg::STOP_IDLE;
      s_d.sda_oe  = 1'b0;
      s_d.scl_oe  = 1'b0;
    end

    // flag-to-interrupt gating
    s_d.irq = |(s_d.irq_flag & s_d.irq_en); // see R23

    // controls to the byte engine
    s_d.ctl.cond_req         = s_d.con2[4:0];
    s_d.ctl.sample_phase_sel = s_d.stat[sync_port_pkg::ST_SAMPLE_PHASE]; // see R09
    s_d.ctl.clock_edge_sel   = s_d.stat[sync_port_pkg::ST_CLOCK_EDGE];   // see R11
    s_d.ctl.slew_disable     = !mode_is_spi(s_d.con1[3:0]) && s_d.stat[sync_port_pkg::ST_SAMPLE_PHASE]; // see R10
    s_d.ctl.smbus_thresh     = !mode_is_spi(s_d.con1[3:0]) && s_d.stat[sync_port_pkg::ST_CLOCK_EDGE];   // see R12
    s_d.ctl.mode             = s_d.con1[3:0];
    s_d.ctl.port_enable      = s_d.con1[sync_port_pkg::C1_PORT_EN];
    s_d.ctl.baud_tick        = s_d.baud_tick;
    s_d.ctl.baud_clk         = s_d.baud_clk;
  end

  // single state register
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q         <= '0;
      s_q.sda_s   <= 3'b111;
      s_q.scl_s   <= 3'b111;
      s_q.sda_f   <= 1'b1;
      s_q.scl_f   <= 1'b1;
      s_q.sda_p   <= 1'b1;
      s_q.scl_p   <= 1'b1;
      s_q.stop_st <= sync_port_pkg::STOP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops, except o_sda and o_scl which are tied low
  assign o_prdata  = s_q.prdata;
  assign o_pready  = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_sda     = 1'b0;
  assign o_scl     = 1'b0;
  assign o_sda_oe  = s_q.sda_oe;
  assign o_scl_oe  = s_q.scl_oe;
  assign o_ctl     = s_q.ctl;
  assign o_irq     = s_q.irq;

endmodule

// ==== logic/sync_port_pkg.sv ====
// constants, register map and carrier types for the serial port stop/baud/status block
package sync_port_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_BAUD_RELOAD  = 8'h00;
  localparam logic [7:0] OFF_SHIFT_BUFFER = 8'h04;
  localparam logic [7:0] OFF_CONTROL_ONE  = 8'h08;
  localparam logic [7:0] OFF_CONTROL_TWO  = 8'h0C;
  localparam logic [7:0] OFF_CONTROL_THR  = 8'h10;
  localparam logic [7:0] OFF_ADDR_MASK    = 8'h14;
  localparam logic [7:0] OFF_PORT_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h1C;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h20;

  // register reset values
  localparam logic [7:0] RST_REG8 = 8'h00;

  // port_status field positions
  localparam int ST_SAMPLE_PHASE = 7;
  localparam int ST_CLOCK_EDGE   = 6;
  localparam int ST_DATA_NADDR   = 5;
  localparam int ST_STOP_SEEN    = 4;
  localparam int ST_START_SEEN   = 3;
  localparam int ST_READ_WRITE   = 2;
  localparam int ST_ADDR_UPDATE  = 1;
  localparam int ST_BUFFER_FULL  = 0;

  // port_control_one field positions
  localparam int C1_WRITE_COLL = 7;
  localparam int C1_PORT_EN    = 5;
  localparam int C1_MODE_HI    = 3;

  // port_control_two request bits
  localparam int C2_ACK_REQ     = 4;
  localparam int C2_RECEIVE_REQ = 3;
  localparam int C2_STOP_REQ    = 2;
  localparam int C2_RESTART_REQ = 1;
  localparam int C2_START_REQ   = 0;
  localparam logic [7:0] C2_REQ_MASK = 8'h1F;

  // interrupt flag/enable bit positions
  localparam int IRQ_BUS_COLL   = 0;
  localparam int IRQ_PORT_EVENT = 1;

  // port modes
  localparam logic [3:0] MODE_SPI_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_SPI_M_TMR   = 4'h3;
  localparam logic [3:0] MODE_I2C_MASTER  = 4'h8;
  localparam logic [3:0] MODE_SPI_M_BAUD  = 4'hA;
  localparam logic [3:0] MODE_SPI_S_LO    = 4'h4;
  localparam logic [3:0] MODE_SPI_S_HI    = 4'h5;

  // baud counter ticks once every this many system clocks
  localparam int          BAUD_PRESCALE = 2;
  localparam logic [1:0]  BAUD_PRE_LAST = 2'(BAUD_PRESCALE - 1);

  // stop sequence states
  typedef enum logic [2:0] {
    STOP_IDLE  = 3'b000,
    STOP_SDA   = 3'b001,
    STOP_SCL   = 3'b010,
    STOP_HOLD  = 3'b011,
    STOP_REL   = 3'b100,
    STOP_DONE  = 3'b101
  } stop_state_t;

  // events from the byte engine that sits beside this block
  typedef struct packed {
    logic       rx_done;
    logic [7:0] rx_data;
    logic       tx_done;
    logic       byte_is_data;
    logic       addr_matched;
    logic       addr_rw;
    logic       nack_seen;
    logic       addr_update;
    logic       xmit_active;
    logic       op_done;
    logic [4:0] req_done;
    logic       sda_low;
    logic       scl_low;
  } engine_evt_t;

  // controls handed to the byte engine
  typedef struct packed {
    logic       tx_load;
    logic [7:0] tx_data;
    logic [4:0] cond_req;
    logic       sample_phase_sel;
    logic       clock_edge_sel;
    logic       slew_disable;
    logic       smbus_thresh;
    logic [3:0] mode;
    logic       port_enable;
    logic       baud_tick;
    logic       baud_clk;
    logic       abort;
  } engine_ctl_t;

endpackage

// ==== verif/i2c_bus_model.sv ====
// wired-and i2c bus with pull-ups and a second master that pulls low on command
`timescale 1ns/10ps
module i2c_bus_model (
  input  wire logic i_sda_oe,
  input  wire logic i_scl_oe,
  input  wire logic i_sda_hold,
  input  wire logic i_scl_hold,
  output logic      o_sda,
  output logic      o_scl
);
  // pull-ups win unless some party pulls low; the holds play the other master
  assign o_sda = !(i_sda_oe || i_sda_hold);
  assign o_scl = !(i_scl_oe || i_scl_hold);
endmodule

// ==== verif/sync_port_assertions.sv ====
// assertion checker on the ports of the serial port core
`timescale 1ns/10ps
module sync_port_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_reset_n,
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [ADDR_W-1:0]          i_paddr,
  input wire logic [31:0]                i_pwdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  input wire logic                       o_sda_oe,
  input wire logic                       o_scl_oe,
  input wire sync_port_pkg::engine_evt_t i_evt,
  input wire sync_port_pkg::engine_ctl_t o_ctl
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // mode classes and address decode
  logic spi;
  logic mst;
  logic mapped;
  assign spi = o_ctl.mode inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hA};
  assign mst = o_ctl.mode inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hA};
  assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= ADDR_W'(sync_port_pkg::OFF_IRQ_ENABLE));

  // bus answer timing and decode
  a_pready_one_wait: assert property (o_pready |-> i_psel && i_penable && $past(i_penable) && !$past(o_pready))
    else $error("pready outside second access cycle");
  a_slverr_decode: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("slverr does not match decode");
  a_load_on_write: assert property (i_psel && i_penable && o_pready && i_pwrite && mst && o_ctl.port_enable
    && o_ctl.cond_req == 5'h00 && !i_evt.xmit_active && i_paddr == ADDR_W'(sync_port_pkg::OFF_SHIFT_BUFFER)
    |=> o_ctl.tx_load && o_ctl.tx_data == 8'($past(i_pwdata))) else $error("buffer write not loaded");
  // pin options per mode and baud counter stop
  a_slew_i2c: assert property ((o_ctl.sample_phase_sel && !spi)[*2] |-> o_ctl.slew_disable)
    else $error("slew control not disabled");
  a_smbus_i2c: assert property ((o_ctl.clock_edge_sel && !spi)[*2] |-> o_ctl.smbus_thresh)
    else $error("smbus thresholds not selected");
  a_spi_no_i2c: assert property (spi[*2] |-> !o_ctl.slew_disable && !o_ctl.smbus_thresh)
    else $error("i2c option active in spi");
  a_tick_stops: assert property (i_evt.op_done |-> ##2 (!o_ctl.baud_tick)[*8])
    else $error("baud counter still running");
  // stop sequence and collision
  a_stop_drives: assert property ($rose(o_ctl.cond_req[sync_port_pkg::C2_STOP_REQ]) && o_ctl.port_enable
    && o_ctl.mode == sync_port_pkg::MODE_I2C_MASTER |-> ##[0:2] (o_sda_oe && o_scl_oe))
    else $error("stop does not pull sda low");
  a_scl_first: assert property ($fell(o_sda_oe) && o_ctl.cond_req[sync_port_pkg::C2_STOP_REQ]
    && !o_ctl.abort |-> !o_scl_oe) else $error("sda released before scl");
  a_abort_release: assert property (o_ctl.abort |-> ##[0:1] (!o_sda_oe && !o_scl_oe && o_ctl.cond_req == 5'h00))
    else $error("abort left pins or requests");
endmodule

bind sync_port_core sync_port_assertions #(.ADDR_W(ADDR_W)) i_chk (
  .i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_pready, .o_pslverr, .o_sda_oe, .o_scl_oe, .i_evt, .o_ctl
);

// ==== verif/tb_top.sv ====
// testbench for the serial port stop, baud and status block
`timescale 1ns/10ps
module tb_top;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       psel = 1'b0, stop_req = 1'b0, pwr = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwd = 32'h0;
  logic                       sda_hold = 1'b0, scl_hold = 1'b0;
  sync_port_pkg::engine_evt_t evt = '0;
  sync_port_pkg::engine_ctl_t ctl;
  logic [31:0]                prdata;
  logic                       pready, pslverr, sda, scl, sda_oe, scl_oe, irq;
  logic [31:0]                rd;
  logic                       err, last;
  logic [5:0]                 mon;
  int                         miscompares = 0;
  int                         comparisons = 0;
  int                         n, h;
  localparam logic [7:0] STS = sync_port_pkg::OFF_PORT_STATUS, CT2 = sync_port_pkg::OFF_CONTROL_TWO,
                         FLG = sync_port_pkg::OFF_IRQ_FLAGS;

  // clock at 125 mhz
  initial begin
    forever #4 clk = ~clk;
  end

  sync_port_core i_dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(stop_req), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe),
    .i_evt(evt), .o_ctl(ctl), .o_irq(irq)
  );
  i2c_bus_model i_bus (.i_sda_oe(sda_oe), .i_scl_oe(scl_oe), .i_sda_hold(sda_hold),
    .i_scl_hold(scl_hold), .o_sda(sda), .o_scl(scl));

  // signals watched by the bounded wait
  assign mon = {irq, ctl.abort, ctl.baud_clk, scl_oe, sda_oe, pready};

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // wait until a watched signal reaches v, counting falling edges
  task automatic wt(input int w, input logic v);
    n = 0;
    while (mon[w] !== v) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask

  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    stop_req <= 1'b1;
    wt(0, 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    stop_req <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), rd, {24'h0, e});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rchk(8'(i * 4), 8'h00);
    end
    apb(1'b0, 8'h24, 8'h00);
    check("slverr", 32'(err), 32'h1);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
    apb(1'b1, STS, 8'hC0);
    rchk(STS, 8'hC0);
    check("spi opts", 32'({ctl.sample_phase_sel, ctl.clock_edge_sel, ctl.slew_disable, ctl.smbus_thresh}), 32'hC);
    apb(1'b1, sync_port_pkg::OFF_CONTROL_ONE, 8'h28);
    @(negedge clk);
    check("i2c opts", 32'({ctl.sample_phase_sel, ctl.clock_edge_sel, ctl.slew_disable, ctl.smbus_thresh}), 32'hF);
    $display("test options done");
    apb(1'b1, sync_port_pkg::OFF_BAUD_RELOAD, 8'h03);
    apb(1'b1, sync_port_pkg::OFF_SHIFT_BUFFER, 8'h5A);
    @(negedge clk);
    check("load", 32'({ctl.tx_load, ctl.tx_data}), 32'h15A);
    rchk(STS, 8'hC1);
    @(negedge clk);
    wt(3, ~mon[3]);
    wt(3, ~mon[3]);
    h = n;
    wt(3, ~mon[3]);
    check("half", h, 8);
    check("period", h + n, 16);
    @(posedge clk);
    evt.tx_done <= 1'b1;
    evt.op_done <= 1'b1;
    @(posedge clk);
    evt.tx_done <= 1'b0;
    evt.op_done <= 1'b0;
    repeat (4) @(negedge clk);
    last = ctl.baud_clk;
    repeat (40) @(negedge clk);
    check("held clk", 32'(ctl.baud_clk), 32'(last));
    rchk(STS, 8'hC0);
    $display("test baud done");
    apb(1'b1, sync_port_pkg::OFF_IRQ_ENABLE, 8'h03);
    apb(1'b1, CT2, 8'h04);
    wt(1, 1'b1);
    wt(2, 1'b0);
    wt(1, 1'b0);
    check("scl to sda", 32'(n >= 10 && n <= 14), 32'h1);
    wt(5, 1'b1);
    repeat (20) @(posedge clk);
    rchk(CT2, 8'h00);
    rchk(FLG, 8'h02);
    rchk(STS, 8'hD0);
    apb(1'b1, FLG, 8'h03);
    repeat (2) @(negedge clk);
    check("irq off", 32'(irq), 32'h0);
    $display("test stop done");
    // scl stolen during the hold, then sda held low past the timeout
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, CT2, 8'h04);
      wt(1, 1'b1);
      wt(2, 1'b0);
      if (c == 0) begin
        repeat (6) @(posedge clk);
        scl_hold <= 1'b1;
      end else begin
        wt(1, 1'b0);
        @(posedge clk);
        sda_hold <= 1'b1;
      end
      wt(4, 1'b1);
      @(negedge clk);
      check("pins free", 32'({sda_oe, scl_oe}), 32'h0);
      rchk(CT2, 8'h00);
      rchk(FLG, 8'h01);
      check("irq on", 32'(irq), 32'h1);
      scl_hold <= 1'b0;
      sda_hold <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b1, FLG, 8'h03);
    end
    $display("test collision done");
    apb(1'b1, sync_port_pkg::OFF_CONTROL_ONE, 8'h08);
    rchk(STS, 8'hC0);
    apb(1'b1, sync_port_pkg::OFF_CONTROL_ONE, 8'h28);
    evt.byte_is_data <= 1'b1;
    evt.xmit_active <= 1'b1;
    rchk(STS, 8'hC4);
    evt.xmit_active <= 1'b0;
    evt.rx_data <= 8'hA5;
    evt.rx_done <= 1'b1;
    @(posedge clk);
    evt.rx_done <= 1'b0;
    rchk(STS, 8'hE1);
    rchk(sync_port_pkg::OFF_SHIFT_BUFFER, 8'hA5);
    rchk(STS, 8'hE0);
    evt.addr_update <= 1'b1;
    @(posedge clk);
    evt.addr_update <= 1'b0;
    rchk(STS, 8'hE2);
    apb(1'b1, sync_port_pkg::OFF_BAUD_RELOAD, 8'h03);
    rchk(STS, 8'hE0);
    $display("test status done");
    tally_and_finish();
  end
endmodule
